// >>> rsp_cfg.svh
// constants for the reference switchover and priority block
// assumes a 125 MHz aclk and a 32-bit AXI4-Lite register port
// Operation
// - priorities span 0 best to 7 worst
// - order by selection, promoted only while active
// - priority algorithm only in automatic, fallback
// - active reference failure forces automatic switchover
// - regained reference wins only beating promoted priority
// - switch to smallest selection priority via map
// - ties go to lowest reference index
// - invalid references never selected, except the user reference in manual
// - phase master when selection below threshold
// - phase master threshold resets to zero
// - build-out on change only for non-masters
// - build-out absorbs old-to-new phase difference
// - slew controller tracks phase, caps output rate
// - sixteen-bit ns/sec limit bounds switchover slew
// - slew limit zero disables controller, resets zero
// - slew error small, accurate credit accumulator
// - fallback keeps valid user reference, else automatic
// - reference without profile treated as invalid
// - mode field 00 auto 01 fallback 10 holdover 11 manual
`ifndef RSP_CFG_SVH
`define RSP_CFG_SVH

// register indices; byte address is four times the index
`define RSP_IDX_SLEW 12'h316
`define RSP_IDX_PBO 12'h507
`define RSP_IDX_LOOP 12'hA01
`define RSP_IDX_SELPRIO 12'h600
`define RSP_IDX_PROMPRIO 12'h601
`define RSP_IDX_STATUS 12'hD20

`define RSP_RST_SLEW 16'h0000
`define RSP_RST_PBO 8'h00
`define RSP_RST_LOOP 8'h00
`define RSP_RST_PRIO 32'h0000_0000

// loop register fields
`define RSP_LOOP_MODE_LSB 3
`define RSP_LOOP_USER_LSB 0

// slew credit: limit in ns/s gives limit*1000 ps/s, one ps step per clk_hz/1000 of credit
`define RSP_CLK_HZ 125000000
`define RSP_PS_PER_NS 1000
`define RSP_SLEW_CREDIT (`RSP_CLK_HZ / `RSP_PS_PER_NS)

`define RSP_RESP_OKAY 2'h0
`define RSP_RESP_DECERR 2'h3

`endif

// >>> rsp_pkg.sv
// types for the reference switchover and priority block
// assumes rsp_cfg.svh holds the numeric constants
package rsp_pkg;

    typedef enum logic [1:0] {
        RSP_AUTO = 2'h0,
        RSP_FALLBACK = 2'h1,
        RSP_HOLDOVER = 2'h2,
        RSP_MANUAL = 2'h3
    } rsp_mode_e;

    // one row of the reference-to-profile table
    typedef struct packed {
        logic assigned;
        logic [2:0] profile;
    } rsp_map_s;

    // selection outcome shown to the loop
    typedef struct packed {
        logic have_ref;
        logic [2:0] active_ref;
        logic phase_master;
        logic slewing;
    } rsp_status_s;

endpackage

// >>> rsp_top.sv
// reference selection, phase build-out decision and phase slew limiting
// assumes validity flags, profile table and phase error come from logic on aclk
`include "rsp_cfg.svh"

module rsp_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] ref_valid,
    input wire rsp_pkg::rsp_map_s [7:0] ref_map,
    input wire logic signed [31:0] phase_err_ps,
    output rsp_pkg::rsp_status_s status,
    output logic signed [31:0] phase_out_ps,
    output logic ref_change,
    output logic build_out,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import rsp_pkg::*;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // register file and AXI4-Lite slave
    // ------------------------------------------------------------
    logic [15:0] slew_q, slew_d;
    logic [7:0] pbo_q, pbo_d;
    logic [7:0] loop_q, loop_d;
    logic [31:0] selprio_q, selprio_d;
    logic [31:0] promprio_q, promprio_d;
    logic aw_q, aw_d, w_q, w_d, bvalid_q, bvalid_d, rvalid_q, rvalid_d;
    logic [11:0] awidx_q, awidx_d;
    logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d, wr_old, wr_new;
    logic [3:0] wstrb_q, wstrb_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic [11:0] aridx;
    logic wr_hit;

    assign s_axi_awready = !aw_q && !bvalid_q;
    assign s_axi_wready = !w_q && !bvalid_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign aridx = s_axi_araddr[13:2];

    always_comb begin
        aw_d = aw_q;
        w_d = w_q;
        awidx_d = awidx_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        slew_d = slew_q;
        pbo_d = pbo_q;
        loop_d = loop_q;
        selprio_d = selprio_q;
        promprio_d = promprio_q;
        wr_old = 32'h0000_0000;
        wr_hit = 1'b1;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_d = 1'b1;
            awidx_d = s_axi_awaddr[13:2];
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_d = 1'b1;
            wdata_d = s_axi_wdata;
            wstrb_d = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        unique case (awidx_q)
            `RSP_IDX_SLEW: wr_old = {16'h0000, slew_q};
            `RSP_IDX_PBO: wr_old = {24'h00_0000, pbo_q};
            `RSP_IDX_LOOP: wr_old = {24'h00_0000, loop_q};
            `RSP_IDX_SELPRIO: wr_old = selprio_q;
            `RSP_IDX_PROMPRIO: wr_old = promprio_q;
            default: wr_hit = 1'b0;
        endcase
        wr_new = merge(wr_old, wdata_q, wstrb_q);
        if (aw_q && w_q) begin
            aw_d = 1'b0;
            w_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = wr_hit ? `RSP_RESP_OKAY : `RSP_RESP_DECERR;
            unique case (awidx_q)
                `RSP_IDX_SLEW: slew_d = wr_new[15:0];
                `RSP_IDX_PBO: pbo_d = wr_new[7:0];
                `RSP_IDX_LOOP: loop_d = wr_new[7:0];
                // three priority bits per profile in each nibble
                `RSP_IDX_SELPRIO: selprio_d = wr_new & 32'h7777_7777;
                `RSP_IDX_PROMPRIO: promprio_d = wr_new & 32'h7777_7777;
                default: ;
            endcase
        end
        if (s_axi_rvalid && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_d = 1'b1;
            rresp_d = `RSP_RESP_OKAY;
            unique case (aridx)
                `RSP_IDX_SLEW: rdata_d = {16'h0000, slew_q};
                `RSP_IDX_PBO: rdata_d = {24'h00_0000, pbo_q};
                `RSP_IDX_LOOP: rdata_d = {24'h00_0000, loop_q};
                `RSP_IDX_SELPRIO: rdata_d = selprio_q;
                `RSP_IDX_PROMPRIO: rdata_d = promprio_q;
                `RSP_IDX_STATUS: rdata_d = {26'h000_0000, status};
                default: begin
                    rdata_d = 32'h0000_0000;
                    rresp_d = `RSP_RESP_DECERR;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            awidx_q <= 12'h000;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= `RSP_RESP_OKAY;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= `RSP_RESP_OKAY;
            slew_q <= `RSP_RST_SLEW;
            pbo_q <= `RSP_RST_PBO;
            loop_q <= `RSP_RST_LOOP;
            selprio_q <= `RSP_RST_PRIO;
            promprio_q <= `RSP_RST_PRIO;
        end else begin
            aw_q <= aw_d;
            w_q <= w_d;
            awidx_q <= awidx_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
            slew_q <= slew_d;
            pbo_q <= pbo_d;
            loop_q <= loop_d;
            selprio_q <= selprio_d;
            promprio_q <= promprio_d;
        end
    end

    // ------------------------------------------------------------
    // reference selection
    // ------------------------------------------------------------
    rsp_mode_e mode;
    logic [2:0] user_ref;
    logic [7:0] cand;
    logic [2:0] sel_pr [8];
    logic [2:0] best_idx, best_pr, act_q, act_d;
    logic best_ok, have_q, have_d, user_ok, act_ok;
    logic [2:0] act_prom;

    assign mode = rsp_mode_e'(loop_q[`RSP_LOOP_MODE_LSB +: 2]);
    assign user_ref = loop_q[`RSP_LOOP_USER_LSB +: 3];
    assign user_ok = cand[user_ref];
    assign act_ok = have_q && cand[act_q];
    // promoted value of the holder, live as soon as act_q moves
    assign act_prom = promprio_q[{ref_map[act_q].profile, 2'b00} +: 3];

    always_comb begin
        best_ok = 1'b0;
        best_idx = 3'h0;
        best_pr = 3'h7;
        for (int i = 0; i < 8; i++) begin
            cand[i] = ref_valid[i] && ref_map[i].assigned;
            sel_pr[i] = selprio_q[{ref_map[i].profile, 2'b00} +: 3];
            // strict compare keeps the lowest index on a tie
            if (cand[i] && (!best_ok || sel_pr[i] < best_pr)) begin
                best_ok = 1'b1;
                best_idx = 3'(i);
                best_pr = sel_pr[i];
            end
        end
    end

    always_comb begin
        act_d = act_q;
        have_d = have_q;
        unique case (mode)
            RSP_AUTO, RSP_FALLBACK: begin
                if (mode == RSP_FALLBACK && user_ok) begin
                    act_d = user_ref;
                    have_d = 1'b1;
                end else if (!act_ok) begin
                    act_d = best_ok ? best_idx : act_q;
                    have_d = best_ok;
                end else if (best_ok && best_pr < act_prom) begin
                    act_d = best_idx;
                end
            end
            RSP_HOLDOVER: begin
                act_d = user_ref;
                have_d = user_ok;
            end
            RSP_MANUAL: begin
                act_d = user_ref;
                have_d = 1'b1;
            end
        endcase
    end

    // ------------------------------------------------------------
    // phase build-out and slew limiting
    // ------------------------------------------------------------
    logic change, master;
    logic signed [31:0] ofs_q, ofs_d, out_q, out_d, target;
    logic [17:0] acc_q, acc_d;
    logic slewing_q, slewing_d, chg_q, pbo_ev_q, pbo_ev_d;

    assign change = have_d && (!have_q || act_d != act_q);
    assign master = {5'h00, sel_pr[act_d]} < pbo_q;

    always_comb begin
        ofs_d = ofs_q;
        acc_d = acc_q;
        out_d = out_q;
        slewing_d = slewing_q;
        pbo_ev_d = 1'b0;
        if (change) begin
            if (!master) begin
                // keep the output where it is across the swap
                ofs_d = phase_err_ps - out_q;
                pbo_ev_d = 1'b1;
            end else begin
                slewing_d = slew_q != 16'h0000;
            end
        end
        // new offset used at once, else a build-out swap glitches the output for a cycle
        target = phase_err_ps - ofs_d;
        // slewing starts on the swap edge itself, so the phase step is never passed through
        if (slew_q == 16'h0000 || !slewing_d) begin
            out_d = target;
            acc_d = 18'h00000;
            slewing_d = slewing_d && slew_q != 16'h0000;
        end else if (out_q == target) begin
            slewing_d = change && slewing_d;
            acc_d = 18'h00000;
        end else begin
            // exact integer credit: rate error is only the 1 ps step quantum
            acc_d = acc_q + 18'(slew_q);
            if (acc_d >= 18'(`RSP_SLEW_CREDIT)) begin
                acc_d = acc_d - 18'(`RSP_SLEW_CREDIT);
                out_d = (target > out_q) ? out_q + 32'sd1 : out_q - 32'sd1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            act_q <= 3'h0;
            have_q <= 1'b0;
            ofs_q <= 32'sh0000_0000;
            out_q <= 32'sh0000_0000;
            acc_q <= 18'h00000;
            slewing_q <= 1'b0;
            chg_q <= 1'b0;
            pbo_ev_q <= 1'b0;
        end else begin
            act_q <= act_d;
            have_q <= have_d;
            ofs_q <= ofs_d;
            out_q <= out_d;
            acc_q <= acc_d;
            slewing_q <= slewing_d;
            chg_q <= change;
            pbo_ev_q <= pbo_ev_d;
        end
    end

    assign status = '{have_ref: have_q, active_ref: act_q,
                      phase_master: have_q && ({5'h00, sel_pr[act_q]} < pbo_q),
                      slewing: slewing_q};
    assign phase_out_ps = out_q;
    assign ref_change = chg_q;
    assign build_out = pbo_ev_q;
endmodule

// >>> rsp_ref_model.sv
// partner: reference sources showing validity and profile map
// assumes the bench requests each new pattern on aclk
module rsp_ref_model (
    input wire logic aclk,
    input wire logic [7:0] want_valid,
    input wire logic [31:0] want_map,
    output logic [7:0] ref_valid,
    output rsp_pkg::rsp_map_s [7:0] ref_map
);
    import rsp_pkg::*;
    // unassigned rows arrive as they are; the block must drop them
    always_ff @(posedge aclk) begin
        ref_valid <= want_valid;
        ref_map <= want_map;
    end
endmodule

// >>> rsp_top_sva.sv
// assertions on the switchover block ports
// assumes one clock domain, synchronous active-low reset
module rsp_top_sva (
    input wire logic aclk,
    input wire logic aresetn,
    input wire rsp_pkg::rsp_status_s status,
    input wire logic ref_change,
    input wire logic build_out,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata
);
    import rsp_pkg::*;
    logic [3:0] prev_d;
    logic [3:0] prev_q;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    always_comb prev_d = {status.have_ref, status.active_ref};
    always_ff @(posedge aclk) begin
        prev_q <= aresetn ? prev_d : 4'h0;
    end
    sequence s_wr_both;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_moved;
        prev_d[3] && prev_d != prev_q;
    endsequence
    a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped early");
    a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped early");
    a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answer pending");
    a_write_answer: assert property (s_wr_both |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_change_pulse: assert property (s_moved |-> ref_change)
        else $error("change pulse missing");
    a_change_cause: assert property (ref_change |-> s_moved)
        else $error("change pulse without move");
    a_build_change: assert property (build_out |-> ref_change)
        else $error("build-out without change");
    a_master_build: assert property (ref_change |-> build_out == !status.phase_master)
        else $error("build-out decision wrong");
endmodule
bind rsp_top rsp_top_sva rsp_top_sva_i (.*);

// >>> rsp_top_tb_top.sv
// self-checking bench: switchover block against a priority model
// assumes design, partner and checker compiled before this file
module rsp_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import rsp_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] want_valid = 8'h00;
    logic [31:0] want_map = 32'h0;
    logic [7:0] ref_valid;
    rsp_map_s [7:0] ref_map;
    logic signed [31:0] phase_err_ps = 32'sh0;
    logic signed [31:0] phase_out_ps;
    logic signed [31:0] last_ps = 32'sh0;
    rsp_status_s status;
    logic ref_change, build_out, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [31:0] s_axi_awaddr = 32'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [31:0] s_axi_araddr = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic m_have = 1'b0, slew_off = 1'b1, seen_slew = 1'b0, was_slew = 1'b0;
    int n_fail = 0, n_tests = 0, m_act = 0, mode = 0, usr = 0, thr = 0;
    int sel[8];
    int prm[8];
    integer seed = 32'hF792;
    rsp_ref_model rsp_ref_model_i (.aclk(aclk), .want_valid(want_valid),
        .want_map(want_map), .ref_valid(ref_valid), .ref_map(ref_map));
    rsp_top rsp_top_i (.*);
    initial forever #4 aclk = ~aclk;
    task automatic final_report();
        if (n_fail == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tmo();
        chk(32'h0, 32'h1);
        final_report();
    endtask
    // bready comes late on purpose so the answer has to stand
    task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
        logic pa, pw, dn;
        int k;
        pa = 1'b1;
        pw = 1'b1;
        dn = 1'b0;
        r = 2'h0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        for (k = 0; k < 40 && !dn; k++) begin
            @(negedge aclk);
            pa = pa && !s_axi_awready;
            pw = pw && !s_axi_wready;
            dn = s_axi_bvalid && s_axi_bready;
            r = s_axi_bresp;
            @(posedge aclk);
            s_axi_awvalid <= pa;
            s_axi_wvalid <= pw;
            s_axi_bready <= !dn && (s_axi_bready || k >= 3);
        end
        if (!dn) tmo();
        @(posedge aclk);
    endtask
    task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        logic pa, dn;
        int k;
        pa = 1'b1;
        dn = 1'b0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        for (k = 0; k < 40 && !dn; k++) begin
            @(negedge aclk);
            pa = pa && !s_axi_arready;
            dn = s_axi_rvalid && s_axi_rready;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
            s_axi_arvalid <= pa;
            s_axi_rready <= !dn && (s_axi_rready || k >= 2);
        end
        if (!dn) tmo();
        @(posedge aclk);
    endtask
    // reference model of the selection, stepped on the same edges as the block
    always @(posedge aclk) begin : mdl
        int i, b, bs, na;
        logic nh, uv, ok;
        b = -1;
        bs = 8;
        for (i = 0; i < 8; i++) begin
            if (ref_valid[i] && ref_map[i].assigned && sel[ref_map[i].profile] < bs) begin
                b = i;
                bs = sel[ref_map[i].profile];
            end
        end
        ok = m_have && ref_valid[m_act] && ref_map[m_act].assigned;
        uv = ref_valid[usr] && ref_map[usr].assigned;
        nh = m_have;
        na = m_act;
        if (mode == 3 || (mode != 0 && uv)) begin
            nh = 1'b1;
            na = usr;
        end else if (mode == 2) begin
            nh = 1'b0;
        end else if (b >= 0 && (!ok || bs < prm[ref_map[m_act].profile])) begin
            nh = 1'b1;
            na = b;
        end else if (!ok) begin
            nh = 1'b0;
        end
        m_have <= aresetn && nh;
        m_act <= aresetn ? na : 0;
    end
    // a limit below the credit size allows at most one ps per clock
    always @(negedge aclk) begin
        if (!slew_off && was_slew && status.slewing === 1'b1) begin
            seen_slew = 1'b1;
            chk(32'($unsigned(phase_out_ps - last_ps + 32'sd1) <= 32'h2), 32'h1);
        end
        if (build_out === 1'b1) chk(phase_out_ps, last_ps);
        was_slew = status.slewing === 1'b1;
        last_ps = phase_out_ps;
    end
    task automatic cmp();
        @(negedge aclk);
        chk(status.have_ref, m_have);
        if (m_have) chk(status.active_ref, m_act[2:0]);
        if (m_have && ref_map[m_act].assigned) begin
            chk(status.phase_master, sel[ref_map[m_act].profile] < thr);
        end
        if (slew_off) chk(status.slewing, 1'b0);
        @(posedge aclk);
    endtask
    // priorities are per profile; all inputs count as single-ended here
    task automatic run(input int n);
        logic [1:0] r;
        int i;
        for (i = 0; i < n; i++) begin
            if (i % 8 == 0) begin
                // mode moves while nothing is valid, so the settled state
                // does not hang on the exact edge the write lands
                want_valid <= 8'h00;
                mode = (i / 8) % 4;
                usr = $unsigned($random(seed)) % 8;
                wr(32'h2804, 32'(mode * 8 + usr), r);
            end
            want_valid <= (i % 8 == 1) ? 8'h00 : 8'($random(seed));
            want_map <= $random(seed);
            @(posedge aclk);
            // phase step arrives with the new validity, as at a real swap
            phase_err_ps <= $random(seed) % 20000;
            repeat (3) @(posedge aclk);
            cmp();
        end
    endtask
    initial begin
        logic [31:0] d, w;
        logic [1:0] r;
        int i;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(32'hC58, d, r);
        chk(d, 32'h0);
        rd(32'h141C, d, r);
        chk(d, 32'h0);
        rd(32'h10, d, r);
        chk(r, 2'h3);
        wr(32'h10, 32'h1, r);
        chk(r, 2'h3);
        w = $random(seed) & 32'h77777777;
        wr(32'h1800, w | 32'h88888888, r);
        for (i = 0; i < 8; i++) sel[i] = w[4 * i +: 3];
        rd(32'h1800, d, r);
        chk(d, w);
        d = $random(seed) & 32'h77777777;
        wr(32'h1804, d, r);
        for (i = 0; i < 8; i++) prm[i] = d[4 * i +: 3];
        run(32);
        thr = 3;
        wr(32'h141C, 32'h3, r);
        run(32);
        wr(32'hC58, 32'hFFFFFFFF, r);
        rd(32'hC58, d, r);
        chk(d, 32'h0000FFFF);
        slew_off = 1'b0;
        thr = 8;
        wr(32'h141C, 32'h8, r);
        run(16);
        chk(seen_slew, 1'b1);
        final_report();
    end
endmodule
